/* File: verilog/hsc_pkg.sv */
// Constants, register map and carried types for the HDLC signaling command block.
// Assumes one 20 MHz clock and an Avalon-MM slave with 32-bit words.
//
// How it works
// - Counter clear zeroes unit and error counters
// - Counter clear bit self-clears after execution
// - Command executed within 2.5 data periods
// - Transparent send: FIFO bytes, no framing
// - Message end appends CRC and flag
// - Tx reset: flush, seven-ones abort, fill
// - Tx reset raises pool-ready interrupt
// - Receive complete frees receive FIFO space
// - Channel 3 repeat plus transparent sends bytes cyclically
// - Cycling stops on reset or repeat cleared
// - Frame command sends up to 32 bytes
// - Channel 2 address push stores received address bytes
// - Channel 2 CRC store: two CRC bytes, status byte
// - CRC still checked, length limits adjusted
// - CRC off: host supplies CRC, flag closes
// - Idle fill: ones or repeated flags
// - Multiframe align bit aligns transmit start
// - Threshold field selects 32/16/4/2 bytes
package hsc_pkg;
  // ------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_HDLC3_COMMAND = 8'h89;
  localparam logic [7:0] IDX_HDLC2_COMMON_CONFIG = 8'h8b;
  localparam logic [7:0] IDX_COUNTER_COMMAND = 8'h90;
  localparam logic [7:0] IDX_HDLC2_COMMAND = 8'h91;
  localparam logic [7:0] IDX_HDLC3_COMMON_CONFIG = 8'h92;
  localparam logic [7:0] IDX_STATUS = 8'h93;
  localparam logic [7:0] RESET_CONFIG = 8'h00;

  // ------------------------------------------------------------
  // Command bit positions
  // ------------------------------------------------------------
  localparam int B_SU_CLEAR = 0;
  localparam int B_RES = 0;
  localparam int B_MEND = 1;
  localparam int B_TRANSP = 2;
  localparam int B_HFRAME = 3;
  localparam int B_REPEAT = 5;
  localparam int B_RMC = 7;
  // Config bit positions
  localparam int B_ADDR_PUSH = 7;
  localparam int B_RX_CRC = 6;
  localparam int B_TX_CRC_OFF = 5;
  localparam int B_IDLE_FLAG = 4;
  localparam int B_MF_ALIGN = 3;
  localparam int B_THR_HI = 1;
  localparam int B_THR_LO = 0;

  // ------------------------------------------------------------
  // Timing: command latency bound of 2.5 data periods
  // ------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int DATA_RATE_HZ = 2048000;
  localparam int LAT_TENTHS = 25;
  localparam int LAT_CYCLES = (LAT_TENTHS * CLK_HZ) / (10 * DATA_RATE_HZ);
  localparam int ABORT_ONES = 7;
  localparam logic [7:0] FLAG = 8'h7e;
  localparam int FIFO_DEPTH = 32;

  // Transmit state per channel
  typedef enum logic [2:0] {
    HSC_IDLE = 3'b000,
    HSC_WAIT_MF = 3'b001,
    HSC_SEND = 3'b011,
    HSC_CRC = 3'b010,
    HSC_CLOSE = 3'b110,
    HSC_ABORT = 3'b111
  } hsc_state_t;

  // Per-channel command pulses and configuration
  typedef struct packed {
    logic res;
    logic mend;
    logic transp;
    logic hframe;
    logic repeat_on;
    logic rmc;
  } hsc_cmd_t;

  typedef struct packed {
    logic addr_push;
    logic rx_crc;
    logic tx_crc_off;
    logic idle_flag;
    logic mf_align;
    logic [1:0] thr;
  } hsc_cfg_t;
endpackage

/* File: verilog/hsc_cmd_cfg.sv */
// HDLC signaling command and configuration block, channels 2 and 3.
// Assumes an Avalon-MM master, a framer multiframe strobe and a bit-rate strobe.
`timescale 1ns/10ps
module hsc_cmd_cfg #(
  parameter int FIFO_DEPTH = hsc_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic bit_tick,
  input wire logic mf_begin,
  input wire logic [7:0] tx_wdata,
  input wire logic [1:0] tx_wr,
  input wire logic [1:0] rx_busy,
  output logic [1:0] tx_bit,
  output logic [1:0] tx_pool_ready_irq,
  output logic [1:0] rx_free,
  output logic [5:0] ch2_rx_limit,
  output logic [5:0] ch3_rx_limit,
  output logic [2:0] ch2_rx_cfg,
  output logic cmd_executing_flag,
  output logic su_counter_clear,
  output logic [15:0] su_count,
  output logic [15:0] su_err_count,
  input wire logic su_event,
  input wire logic su_error
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Accessible receive FIFO size per threshold code
  function automatic logic [5:0] thr_size(input logic [1:0] code);
    case (code)
      2'b00: thr_size = 6'h20;
      2'b01: thr_size = 6'h10;
      2'b10: thr_size = 6'h04;
      default: thr_size = 6'h02;
    endcase
  endfunction

  // Unpack a command byte into pulses
  function automatic hsc_pkg::hsc_cmd_t cmd_of(input logic [7:0] d, input logic hit);
    cmd_of.res = hit & d[hsc_pkg::B_RES];
    cmd_of.mend = hit & d[hsc_pkg::B_MEND];
    cmd_of.transp = hit & d[hsc_pkg::B_TRANSP];
    cmd_of.hframe = hit & d[hsc_pkg::B_HFRAME];
    cmd_of.repeat_on = hit & d[hsc_pkg::B_REPEAT];
    cmd_of.rmc = hit & d[hsc_pkg::B_RMC];
  endfunction

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  logic ack;
  logic [7:0] cfg2;
  logic [7:0] cfg3;
  logic ch3_tx_repeat;
  logic [1:0] active;
  wire [7:0] idx = avs_address[9:2];
  wire req = (avs_read | avs_write) & ~ack;
  wire lane0 = avs_byteenable[0];
  wire wr = avs_write & ~ack & lane0;
  wire hit_cmd3 = (idx == hsc_pkg::IDX_HDLC3_COMMAND);
  wire hit_cfg2 = (idx == hsc_pkg::IDX_HDLC2_COMMON_CONFIG);
  wire hit_ctr = (idx == hsc_pkg::IDX_COUNTER_COMMAND);
  wire hit_cmd2 = (idx == hsc_pkg::IDX_HDLC2_COMMAND);
  wire hit_cfg3 = (idx == hsc_pkg::IDX_HDLC3_COMMON_CONFIG);
  wire hit_stat = (idx == hsc_pkg::IDX_STATUS);
  wire mapped = hit_cmd3 | hit_cfg2 | hit_ctr | hit_cmd2 | hit_cfg3 | hit_stat;
  wire [7:0] wd = avs_writedata[7:0];

  // Commands only read as zero; they act on the write cycle itself
  logic [7:0] rsel;
  always_comb begin
    if (hit_cfg2) begin
      rsel = cfg2;
    end else if (hit_cfg3) begin
      rsel = cfg3;
    end else if (hit_stat) begin
      rsel = {4'h0, active, ch3_tx_repeat, cmd_executing_flag};
    end else begin
      rsel = 8'h00;
    end
  end

  // One wait cycle, then answer; unmapped answers slave error
  always_ff @(posedge clk) begin
    if (reset) begin
      ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'b00;
    end else if (clk_en) begin
      ack <= req;
      avs_readdata <= {24'h000000, rsel};
      avs_response <= mapped ? 2'b00 : 2'b10;
    end
  end
  assign avs_waitrequest = ~ack;

  // ------------------------------------------------------------
  // Command pulses and configuration registers
  // ------------------------------------------------------------
  wire hsc_pkg::hsc_cmd_t c2 = cmd_of(wd, wr & hit_cmd2 & mapped);
  wire hsc_pkg::hsc_cmd_t c3 = cmd_of(wd, wr & hit_cmd3);
  wire su_wr = wr & hit_ctr & wd[hsc_pkg::B_SU_CLEAR];

  always_ff @(posedge clk) begin
    if (reset) begin
      cfg2 <= hsc_pkg::RESET_CONFIG;
      cfg3 <= hsc_pkg::RESET_CONFIG;
    end else if (clk_en) begin
      if (wr & hit_cfg2) cfg2 <= wd;
      if (wr & hit_cfg3) cfg3 <= wd;
    end
  end

  // Repeat is a level held until written off or reset command
  always_ff @(posedge clk) begin
    if (reset) begin
      ch3_tx_repeat <= 1'b0;
    end else if (clk_en) begin
      if (c3.res) begin
        ch3_tx_repeat <= 1'b0;
      end else if (wr & hit_cmd3) begin
        ch3_tx_repeat <= wd[hsc_pkg::B_REPEAT];
      end
    end
  end

  // Receive thresholds and frame-store options
  always_ff @(posedge clk) begin
    if (reset) begin
      ch2_rx_limit <= 6'h20;
      ch3_rx_limit <= 6'h20;
      ch2_rx_cfg <= 3'b000;
      rx_free <= 2'b00;
    end else if (clk_en) begin
      ch2_rx_limit <= thr_size(cfg2[hsc_pkg::B_THR_HI:hsc_pkg::B_THR_LO]);
      ch3_rx_limit <= thr_size(cfg3[hsc_pkg::B_THR_HI:hsc_pkg::B_THR_LO]);
      // Receiver uses these: push address, store CRC+status, keep CRC check
      ch2_rx_cfg <= {cfg2[hsc_pkg::B_ADDR_PUSH], cfg2[hsc_pkg::B_RX_CRC], 1'b1};
      rx_free <= {c3.rmc, c2.rmc};
    end
  end

  // ------------------------------------------------------------
  // Counter clear command
  // ------------------------------------------------------------
  // Pending bit stands until a data-bit tick or the latency bound executes it
  logic [4:0] lat_cnt;
  always_ff @(posedge clk) begin
    if (reset) begin
      su_counter_clear <= 1'b0;
      cmd_executing_flag <= 1'b0;
      lat_cnt <= 5'h00;
      su_count <= 16'h0000;
      su_err_count <= 16'h0000;
    end else if (clk_en) begin
      if (su_wr) begin
        su_counter_clear <= 1'b1;
        cmd_executing_flag <= 1'b1;
        lat_cnt <= 5'h00;
      end else if (su_counter_clear) begin
        lat_cnt <= lat_cnt + 5'h01;
        // Executes on a bit tick, or forced at the latency bound
        if (bit_tick || lat_cnt >= 5'(hsc_pkg::LAT_CYCLES - 2)) begin
          su_counter_clear <= 1'b0;
          cmd_executing_flag <= 1'b0;
        end
      end
      if (su_counter_clear && (bit_tick || lat_cnt >= 5'(hsc_pkg::LAT_CYCLES - 2))) begin
        su_count <= 16'h0000;
        su_err_count <= 16'h0000;
      end else begin
        if (su_event) su_count <= su_count + 16'h0001;
        if (su_error) su_err_count <= su_err_count + 16'h0001;
      end
    end
  end

  // ------------------------------------------------------------
  // Transmit channels (index 0 = channel 2, 1 = channel 3)
  // ------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_tx
      wire hsc_pkg::hsc_cmd_t c = (ch == 0) ? c2 : c3;
      wire [7:0] cfg = (ch == 0) ? cfg2 : cfg3;
      wire rep = (ch == 0) ? 1'b0 : ch3_tx_repeat;
      logic [7:0] mem [FIFO_DEPTH];
      logic [5:0] wptr;
      logic [5:0] rptr;
      logic [2:0] bitn;
      logic [7:0] sh;
      logic [15:0] crc;
      logic transp;
      logic crc_off;
      logic closing;
      logic [2:0] ones;
      hsc_pkg::hsc_state_t st;
      wire start = c.transp | c.hframe | c.mend;
      wire empty = (rptr == wptr);
      wire [7:0] cur = mem[rptr[4:0]];
      wire fb = crc[15] ^ cur[bitn];

      // Byte loading from the host side
      always_ff @(posedge clk) begin
        if (clk_en && tx_wr[ch] && wptr < 6'(FIFO_DEPTH)) begin
          mem[wptr[4:0]] <= tx_wdata;
        end
      end

      always_ff @(posedge clk) begin
        if (reset) begin
          st <= hsc_pkg::HSC_IDLE;
          wptr <= 6'h00;
          rptr <= 6'h00;
          bitn <= 3'h0;
          sh <= hsc_pkg::FLAG;
          crc <= 16'hffff;
          transp <= 1'b0;
          crc_off <= 1'b0;
          closing <= 1'b0;
          ones <= 3'h0;
          tx_bit[ch] <= 1'b1;
          tx_pool_ready_irq[ch] <= 1'b0;
          active[ch] <= 1'b0;
        end else if (clk_en) begin
          tx_pool_ready_irq[ch] <= 1'b0;
          if (tx_wr[ch] && wptr < 6'(FIFO_DEPTH)) wptr <= wptr + 6'h01;
          if (c.res) begin
            // Flush and abort, then return to fill
            wptr <= 6'h00;
            rptr <= 6'h00;
            ones <= 3'h0;
            st <= hsc_pkg::HSC_ABORT;
            tx_pool_ready_irq[ch] <= 1'b1;
          end else if (start && st == hsc_pkg::HSC_IDLE) begin
            transp <= c.transp;
            crc_off <= cfg[hsc_pkg::B_TX_CRC_OFF];
            closing <= c.mend | c.hframe;
            crc <= 16'hffff;
            ones <= 3'h0; // CRC stage counts from a clean start
            bitn <= 3'h0;
            st <= cfg[hsc_pkg::B_MF_ALIGN] ? hsc_pkg::HSC_WAIT_MF : hsc_pkg::HSC_SEND;
          end else if (bit_tick) begin
            case (st)
              hsc_pkg::HSC_IDLE: begin
                // Fill: ones, or flags when selected
                tx_bit[ch] <= cfg[hsc_pkg::B_IDLE_FLAG] ? sh[bitn] : 1'b1;
                bitn <= bitn + 3'h1;
              end
              hsc_pkg::HSC_WAIT_MF: begin
                if (mf_begin) st <= hsc_pkg::HSC_SEND;
              end
              hsc_pkg::HSC_SEND: begin
                active[ch] <= 1'b1;
                if (empty) begin
                  active[ch] <= 1'b0;
                  st <= hsc_pkg::HSC_IDLE;
                end else begin
                  tx_bit[ch] <= cur[bitn];
                  crc <= {crc[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
                  bitn <= bitn + 3'h1;
                  if (bitn == 3'h7) begin
                    if (rptr + 6'h01 != wptr) begin
                      rptr <= rptr + 6'h01;
                    end else if (transp && rep) begin
                      rptr <= 6'h00;
                    end else if (transp) begin
                      rptr <= 6'h00;
                      wptr <= 6'h00;
                      st <= hsc_pkg::HSC_IDLE;
                      tx_pool_ready_irq[ch] <= 1'b1;
                    end else begin
                      rptr <= 6'h00;
                      wptr <= 6'h00;
                      st <= (closing && !crc_off) ? hsc_pkg::HSC_CRC : hsc_pkg::HSC_CLOSE;
                    end
                  end
                end
              end
              hsc_pkg::HSC_CRC: begin
                tx_bit[ch] <= ~crc[15];
                crc <= {crc[14:0], 1'b1};
                ones <= ones + 3'h1;
                if (ones == 3'h7) begin
                  bitn <= bitn + 3'h1;
                  if (bitn == 3'h1) begin
                    // Closing flag must start at its first bit
                    bitn <= 3'h0;
                    st <= hsc_pkg::HSC_CLOSE;
                  end
                end
              end
              hsc_pkg::HSC_CLOSE: begin
                tx_bit[ch] <= sh[bitn];
                bitn <= bitn + 3'h1;
                if (bitn == 3'h7) begin
                  active[ch] <= 1'b0;
                  tx_pool_ready_irq[ch] <= 1'b1;
                  st <= hsc_pkg::HSC_IDLE;
                end
              end
              default: begin
                tx_bit[ch] <= 1'b1;
                ones <= ones + 3'h1;
                if (ones == 3'(hsc_pkg::ABORT_ONES - 1)) begin
                  active[ch] <= 1'b0;
                  bitn <= 3'h0;
                  st <= hsc_pkg::HSC_IDLE;
                end
              end
            endcase
          end
        end
      end
    end
  endgenerate
endmodule

/* File: bench/hsc_cmd_cfg_props.sv */
// Checker for the HDLC signaling command block, bound to its top module.
// Assumes clk_en is held high whenever the checker is armed.
`timescale 1ns/10ps
module hsc_cmd_cfg_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  input wire logic [1:0] tx_pool_ready_irq,
  input wire logic [1:0] rx_free,
  input wire logic [5:0] ch2_rx_limit,
  input wire logic cmd_executing_flag,
  input wire logic su_counter_clear,
  input wire logic [15:0] su_count,
  input wire logic [15:0] su_err_count
);
  // ----------------------------------------
  // Address decode helpers
  // ----------------------------------------
  localparam int LAT = 24;
  wire logic [7:0] idx = avs_address[9:2];
  wire logic is_cmd = idx == hsc_pkg::IDX_HDLC3_COMMAND || idx == hsc_pkg::IDX_HDLC2_COMMAND;
  wire logic mapped = is_cmd || idx == hsc_pkg::IDX_HDLC2_COMMON_CONFIG ||
    idx == hsc_pkg::IDX_COUNTER_COMMAND || idx == hsc_pkg::IDX_HDLC3_COMMON_CONFIG ||
    idx == hsc_pkg::IDX_STATUS;
  wire logic clr_taken = avs_write && avs_waitrequest && avs_byteenable[0] &&
    idx == hsc_pkg::IDX_COUNTER_COMMAND && avs_writedata[0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_cmd_reads_zero: assert property (avs_read && !avs_waitrequest && is_cmd |-> avs_readdata == 32'h0)
    else $error("command register read back nonzero");
  a_unmapped_resp: assert property (avs_read && !avs_waitrequest && !mapped |-> avs_response == 2'h2)
    else $error("unmapped read not answered with error response");
  a_clear_starts: assert property (clr_taken |=> su_counter_clear && cmd_executing_flag)
    else $error("counter clear did not start after write");
  a_clear_bounded: assert property ($rose(su_counter_clear) |-> ##[1:LAT] !su_counter_clear)
    else $error("counter clear not finished in time");
  a_clear_zeroes: assert property ($fell(su_counter_clear) |-> su_count == 16'h0 && su_err_count == 16'h0)
    else $error("counters not zero when clear completes");
  a_flag_covers: assert property (su_counter_clear |-> cmd_executing_flag)
    else $error("executing flag low while clear pending");
  a_irq_pulse: assert property (tx_pool_ready_irq[0] |=> !tx_pool_ready_irq[0])
    else $error("pool ready pulse longer than one cycle");
  a_free_pulse: assert property (rx_free[1] |=> !rx_free[1])
    else $error("receive free pulse longer than one cycle");
  a_limit_legal: assert property (ch2_rx_limit inside {6'h20, 6'h10, 6'h04, 6'h02})
    else $error("receive limit outside the four sizes");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
endmodule
bind hsc_cmd_cfg hsc_cmd_cfg_props chk_u (.clk(clk), .reset(reset), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response(avs_response), .tx_pool_ready_irq(tx_pool_ready_irq), .rx_free(rx_free),
  .ch2_rx_limit(ch2_rx_limit), .cmd_executing_flag(cmd_executing_flag),
  .su_counter_clear(su_counter_clear), .su_count(su_count), .su_err_count(su_err_count));

/* File: bench/hsc_host_model.sv */
// Host processor model: Avalon-MM master that issues register accesses.
// Assumes the slave answers with waitrequest low; every wait is bounded.
`timescale 1ns/10ps
module hsc_host_model (
  input wire logic clk,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic [1:0] avs_response,
  output logic [9:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable
);
  logic [1:0] last_resp = 2'h0;
  int tmo = 0;
  initial begin
    avs_address = 10'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
  end
  // One access: request held until waitrequest is seen low at a rising edge
  task automatic xfer(input logic rd, input logic [7:0] idx, input logic [7:0] d,
                      input logic [3:0] be, output logic [31:0] q);
    int n;
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    // Waitrequest and read data are taken at the rising edge that ends the wait
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 20) tmo++;
    q = avs_readdata;
    last_resp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Poll the executing flag so a fast host never loses a command
  task automatic poll_idle();
    logic [31:0] q;
    int n;
    for (n = 0; n < 40; n++) begin
      xfer(1'b1, hsc_pkg::IDX_STATUS, 8'h0, 4'hf, q);
      if (q[0] === 1'b0) break;
    end
    if (n == 40) tmo++;
  endtask
endmodule

/* File: bench/hsc_cmd_cfg_tb.sv */
// Self-checking bench for the HDLC signaling command block.
// Assumes the host model drives the bus; bit and multiframe strobes come from here.
`timescale 1ns/10ps
module hsc_cmd_cfg_tb;
  logic clk = 0, reset = 1, bit_tick = 0, mf_begin = 0, su_event = 0, su_error = 0;
  logic [7:0] tx_wdata = 8'h0;
  logic [1:0] tx_wr = 2'h0;
  logic [9:0] adr;
  logic rd_s, wr_s, wt;
  logic [31:0] wd, q, rdat;
  logic [3:0] be;
  logic [1:0] resp, tx_bit, irq, rfree;
  logic [5:0] lim2, lim3;
  logic [2:0] cfg2;
  logic exe, clr;
  logic [15:0] cnt, ecnt;
  int mismatches = 0, tests_run = 0, seed = 32'hdcec, cyc = 0, m[2], n, k, z;
  initial forever #25 clk = ~clk;
  // Line bit strobe every tenth cycle, roughly the 2.048 MHz data rate
  always @(posedge clk) begin
    cyc <= cyc + 1;
    bit_tick <= (cyc % 10) == 9;
    mf_begin <= (cyc % 320) == 0;
  end
  hsc_host_model host_u (.clk(clk), .avs_waitrequest(wt), .avs_readdata(rdat),
    .avs_response(resp), .avs_address(adr), .avs_read(rd_s), .avs_write(wr_s),
    .avs_writedata(wd), .avs_byteenable(be));
  hsc_cmd_cfg dut_u (.clk(clk), .reset(reset), .clk_en(1'b1), .avs_address(adr),
    .avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata(rdat), .avs_waitrequest(wt), .avs_response(resp), .bit_tick(bit_tick),
    .mf_begin(mf_begin), .tx_wdata(tx_wdata), .tx_wr(tx_wr), .rx_busy(2'h0), .tx_bit(tx_bit),
    .tx_pool_ready_irq(irq), .rx_free(rfree), .ch2_rx_limit(lim2), .ch3_rx_limit(lim3),
    .ch2_rx_cfg(cfg2), .cmd_executing_flag(exe), .su_counter_clear(clr), .su_count(cnt),
    .su_err_count(ecnt), .su_event(su_event), .su_error(su_error));
  // ----------------------------------------
  // Compare, report and bus helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    host_u.xfer(1'b0, i, d, 4'hf, q);
  endtask
  task automatic rd(input logic [7:0] i);
    host_u.xfer(1'b1, i, 8'h0, 4'hf, q);
  endtask
  function automatic int lim(input int c);
    return c == 0 ? 32 : c == 1 ? 16 : c == 2 ? 4 : 2;
  endfunction
  // Watch one channel output for a count of cycles, checking whether an event was seen
  task automatic see(input string nm, input int ch, input int len, input int e);
    z = 0;
    for (k = 0; k < len; k++) begin
      @(negedge clk);
      if (ch == 0 && irq[0] === 1'b1) z = 1;
      if (ch == 1 && rfree[1] === 1'b1) z = 1;
      if (ch == 2 && tx_bit[0] === 1'b0) z = 1;
      if (ch == 3 && irq[1] === 1'b1) z = 1;
    end
    chk(nm, e, z);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rd(hsc_pkg::IDX_HDLC3_COMMON_CONFIG);
    chk("cfg3 reset", 32'h0, q);
    chk("limit reset", 32, lim3);
    rd(hsc_pkg::IDX_HDLC3_COMMAND);
    chk("cmd read", 32'h0, q);
    rd(8'h00);
    chk("unmapped resp", 2'h2, host_u.last_resp);
    $display("test reset_map done");
    m[0] = 0;
    m[1] = 0;
    for (n = 0; n < 8; n++) begin
      m[n % 2] = ($random(seed) & 8'hf8) | ((n / 2) & 3);
      wr(n % 2 ? hsc_pkg::IDX_HDLC3_COMMON_CONFIG : hsc_pkg::IDX_HDLC2_COMMON_CONFIG, m[n % 2]);
      rd(n % 2 ? hsc_pkg::IDX_HDLC3_COMMON_CONFIG : hsc_pkg::IDX_HDLC2_COMMON_CONFIG);
      chk("cfg read", m[n % 2], q);
      chk("limit", lim(m[n % 2] & 3), n % 2 ? lim3 : lim2);
      if (n % 2 == 0) chk("rx cfg", {m[0][7], m[0][6], 1'b1}, cfg2);
    end
    host_u.xfer(1'b0, hsc_pkg::IDX_HDLC2_COMMON_CONFIG, 8'hff, 4'h0, q);
    rd(hsc_pkg::IDX_HDLC2_COMMON_CONFIG);
    chk("refused write", m[0], q);
    $display("test config done");
    z = 2 + ($random(seed) & 7);
    repeat (z) begin
      @(posedge clk) su_event <= 1'b1;
      su_error <= 1'b1;
      @(posedge clk) su_event <= 1'b0;
      su_error <= 1'b0;
    end
    @(negedge clk);
    chk("unit count", z, cnt);
    chk("error count", z, ecnt);
    host_u.poll_idle();
    wr(hsc_pkg::IDX_COUNTER_COMMAND, 8'h01);
    for (k = 0; k < 40 && clr !== 1'b0; k++) @(negedge clk);
    chk("clear bounded", 1, k < 40);
    chk("unit cleared", 0, cnt);
    chk("error cleared", 0, ecnt);
    $display("test counter done");
    wr(hsc_pkg::IDX_HDLC2_COMMON_CONFIG, 8'h00);
    fork
      wr(hsc_pkg::IDX_HDLC2_COMMAND, 8'h01);
      see("pool ready", 0, 200, 1);
    join
    see("idle ones", 2, 400, 0);
    wr(hsc_pkg::IDX_HDLC2_COMMON_CONFIG, 8'h10);
    see("idle flags", 2, 400, 1);
    fork
      wr(hsc_pkg::IDX_HDLC3_COMMAND, 8'h80);
      see("rx free", 1, 20, 1);
    join
    $display("test tx_rx done");
    for (n = 0; n < 2; n++) begin
      repeat (3) begin
        @(posedge clk) tx_wr <= 2'h2;
        tx_wdata <= $random(seed);
        @(posedge clk) tx_wr <= 2'h0;
      end
      wr(hsc_pkg::IDX_HDLC3_COMMAND, 8'h24);
      rd(hsc_pkg::IDX_STATUS);
      chk("repeat on", 1, q[1]);
      wr(hsc_pkg::IDX_HDLC3_COMMAND, n ? 8'h04 : 8'h01);
      rd(hsc_pkg::IDX_STATUS);
      chk("repeat off", 0, q[1]);
    end
    fork
      wr(hsc_pkg::IDX_HDLC3_COMMAND, 8'h01);
      see("pool ready3", 3, 20, 1);
    join
    chk("host timeouts", 0, host_u.tmo);
    $display("test repeat done");
    tally_and_finish();
  end
endmodule
